// ### core/cac_pkg.sv
package cac_pkg;

  // cache geometry
  localparam int CAC_WORDS      = 64;
  localparam int CAC_LINES      = 16;
  localparam int CAC_LINE_WORDS = 4;
  localparam int CAC_TAG_W      = 24;

  // register byte offsets
  localparam logic [7:0] CAC_OFS_CCR   = 8'h00;
  localparam logic [7:0] CAC_OFS_CACHE_ADDRESS_REG  = 8'h04;
  localparam logic [7:0] CAC_OFS_ACR0  = 8'h08;
  localparam logic [7:0] CAC_OFS_ACR1  = 8'h0c;
  localparam logic [7:0] CAC_OFS_AUSR  = 8'h10;
  localparam logic [7:0] CAC_OFS_SRCFC = 8'h14;
  localparam logic [7:0] CAC_OFS_DSTFC = 8'h18;
  localparam logic [7:0] CAC_OFS_PROBE = 8'h1c;

  // cache_control_reg fields
  localparam int CCR_IEN   = 0;
  localparam int CCR_ICLRE = 2;
  localparam int CCR_ICLR  = 3;
  localparam int CCR_DEN   = 8;
  localparam int CCR_DCLRE = 10;
  localparam int CCR_DCLR  = 11;
  localparam int CCR_WA    = 13;
  localparam int CCR_BUSY  = 31;

  // access control register fields
  localparam int ACR_BASE_HI = 31;
  localparam int ACR_BASE_LO = 24;
  localparam int ACR_MASK_HI = 22;
  localparam int ACR_MASK_LO = 16;
  localparam int ACR_EN      = 15;
  localparam int ACR_CI      = 10;
  localparam int ACR_RW      = 9;
  localparam int ACR_RWM     = 8;
  localparam int ACR_FCB_HI  = 6;
  localparam int ACR_FCB_LO  = 4;
  localparam int ACR_FCM_HI  = 2;
  localparam int ACR_FCM_LO  = 0;
  // writable bits; mask bit 23 stays zero so a segment is 16 MB .. 2 GB
  localparam logic [31:0] ACR_WMASK = 32'hff7f_8777;

  // probe register fields
  localparam int PRB_RD = 3;

  // reset values
  localparam logic [31:0] CAC_RST_WORD = 32'h0000_0000;
  localparam logic [2:0]  CAC_RST_FC   = 3'h0;

  typedef enum logic [1:0] {
    CAC_F_IDLE = 2'b01,
    CAC_F_BUSY = 2'b10
  } cac_fill_st_t;

endpackage : cac_pkg

// ### core/cac_cache_if.sv
`timescale 1ns/1ps
interface cac_cache_if;
  logic         lk_req;
  logic         lk_use;
  logic         lk_write;
  logic [31:0]  lk_addr;
  logic [31:0]  lk_wdata;
  logic         ack;
  logic         hit;
  logic         miss;
  logic [31:0]  rdata;
  logic         fill_en;
  logic [31:0]  fill_addr;
  logic [127:0] fill_line;
  logic         inv_all;
  logic         inv_line;
  logic [31:0]  inv_addr;

  modport ctl (
    output lk_req, lk_use, lk_write, lk_addr, lk_wdata,
    output fill_en, fill_addr, fill_line, inv_all, inv_line, inv_addr,
    input  ack, hit, miss, rdata
  );
  modport cache (
    input  lk_req, lk_use, lk_write, lk_addr, lk_wdata,
    input  fill_en, fill_addr, fill_line, inv_all, inv_line, inv_addr,
    output ack, hit, miss, rdata
  );
endinterface : cac_cache_if

// ### core/cac_cache.sv
`timescale 1ns/1ps
module cac_cache
  import cac_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control side
  cac_cache_if.cache c
);

  typedef struct packed {
    logic [CAC_LINES-1:0]                valid;
    logic [CAC_LINES-1:0][CAC_TAG_W-1:0] tag;
    logic [CAC_WORDS-1:0][31:0]          data;
    logic                                ack;
    logic                                hit;
    logic                                miss;
    logic [31:0]                         rdata;
  } cac_cache_st_t;

  cac_cache_st_t r_reg;
  cac_cache_st_t r_next;

  logic [3:0] li;
  logic [5:0] wi;
  logic [3:0] fl;
  logic       tag_ok;

  assign li     = c.lk_addr[7:4];
  assign wi     = c.lk_addr[7:2];
  assign fl     = c.fill_addr[7:4];
  assign tag_ok = r_reg.valid[li] && r_reg.tag[li] == c.lk_addr[31:8];

  always_comb
  begin
    r_next      = r_reg;
    r_next.ack  = c.lk_req;
    r_next.hit  = 1'b0;
    r_next.miss = 1'b0;
    // a fill writes its line only as a whole, after its burst is complete
    if (c.fill_en)
    begin
      for (int k = 0; k < CAC_LINE_WORDS; k++)
        r_next.data[{fl, 2'(k)}] = c.fill_line[32*k +: 32];
      r_next.tag[fl]   = c.fill_addr[31:8];
      r_next.valid[fl] = 1'b1;
    end
    // lookups run against held lines while a fill is still on the bus
    if (c.lk_req && c.lk_use)
    begin
      if (tag_ok)
      begin
        r_next.hit = 1'b1;
        if (c.lk_write)
          r_next.data[wi] = c.lk_wdata;
        else
          r_next.rdata = r_reg.data[wi];
      end
      else
        r_next.miss = 1'b1;
    end
    else if (c.lk_req)
      r_next.miss = 1'b0;
    // invalidation wins over a fill landing in the same cycle
    if (c.inv_line)
      r_next.valid[c.inv_addr[7:4]] = 1'b0;
    if (c.inv_all)
      r_next.valid = '0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign c.ack   = r_reg.ack;
  assign c.hit   = r_reg.hit;
  assign c.miss  = r_reg.miss;
  assign c.rdata = r_reg.rdata;

endmodule : cac_cache

// ### core/cac_top.sv
`timescale 1ns/1ps
module cac_top
  import cac_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [2:0]  pprot,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // instruction fetch side
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  input  wire logic [2:0]  i_fc,
  output logic             i_ack,
  output logic             i_hit,
  output logic      [31:0] i_rdata,
  // data side
  input  wire logic        d_req,
  input  wire logic        d_write,
  input  wire logic        d_alt,
  input  wire logic [31:0] d_addr,
  input  wire logic [2:0]  d_fc,
  input  wire logic [31:0] d_wdata,
  output logic             d_ack,
  output logic             d_hit,
  output logic      [31:0] d_rdata,
  // bus controller: line fill
  output logic             fill_req,
  output logic      [31:0] fill_addr,
  input  wire logic        fill_valid,
  input  wire logic        fill_err,
  input  wire logic [31:0] fill_data,
  // bus controller: write-through
  output logic             wt_valid,
  output logic      [31:0] wt_addr,
  output logic      [31:0] wt_data,
  // address space pins
  output logic             space_code_bit0,
  output logic             space_code_bit1,
  output logic             space_code_bit2
);

  typedef struct packed {
    logic                 ien;
    logic                 den;
    logic                 walloc;
    logic [31:0]          cache_address_reg;
    logic [31:0]          acr0;
    logic [31:0]          acr1;
    logic [3:0]           ausr;
    logic [2:0]           source_space_code_reg;
    logic [2:0]           dfc;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    cac_fill_st_t         fst;
    logic                 fill_is_d;
    logic [31:0]          faddr;
    logic [2:0]           ffc;
    logic [1:0]           beat;
    logic [3:0][31:0]     fbuf;
    logic                 fill_en;
    logic                 fill_req;
    logic                 inv_all_i;
    logic                 inv_all_d;
    logic                 inv_line_i;
    logic                 inv_line_d;
    logic [31:0]          i_addr_q;
    logic [2:0]           i_fc_q;
    logic [31:0]          d_addr_q;
    logic [2:0]           d_fc_q;
    logic                 d_wr_q;
    logic                 wt_valid;
    logic [31:0]          wt_addr;
    logic [31:0]          wt_data;
    logic [2:0]           sc;
  } cac_top_st_t;

  cac_top_st_t r_reg;
  cac_top_st_t r_next;

  cac_cache_if ic ();
  cac_cache_if dc ();

  // one segment register against one access
  function automatic logic acu_hit(
    input logic [31:0] acr,
    input logic [31:0] addr,
    input logic        rd,
    input logic [2:0]  fc
  );
    logic [7:0] amask;
    logic       a_ok;
    logic       d_ok;
    logic       f_ok;
    amask = {1'b0, acr[ACR_MASK_HI:ACR_MASK_LO]};
    a_ok  = ((addr[31:24] ^ acr[ACR_BASE_HI:ACR_BASE_LO]) & ~amask) == '0;
    d_ok  = acr[ACR_RWM] || (acr[ACR_RW] == rd);
    f_ok  = ((fc ^ acr[ACR_FCB_HI:ACR_FCB_LO]) &
             ~acr[ACR_FCM_HI:ACR_FCM_LO]) == '0;
    acu_hit = acr[ACR_EN] && a_ok && d_ok && f_ok;
  endfunction : acu_hit

  // cacheability over both segments
  function automatic logic acu_cacheable(
    input logic [31:0] a0,
    input logic [31:0] a1,
    input logic [31:0] addr,
    input logic        rd,
    input logic [2:0]  fc
  );
    logic h0;
    logic h1;
    h0 = acu_hit(a0, addr, rd, fc);
    h1 = acu_hit(a1, addr, rd, fc);
    // no match leaves the access cacheable; any inhibiting match bypasses
    acu_cacheable = !((h0 && a0[ACR_CI]) || (h1 && a1[ACR_CI]));
  endfunction : acu_cacheable

  logic [2:0]  d_fc_eff;
  logic        apb_acc;
  logic        apb_done;
  logic        reg_known;
  logic [31:0] rd_mux;

  // alternate space codes replace the core's code on request
  assign d_fc_eff = d_alt ? (d_write ? r_reg.dfc : r_reg.source_space_code_reg) : d_fc;

  assign apb_acc  = psel && penable && !r_reg.pready;
  assign apb_done = psel && penable && r_reg.pready;

  always_comb
  begin
    reg_known = 1'b1;
    rd_mux    = '0;
    case (paddr)
      CAC_OFS_CCR:
      begin
        rd_mux[CCR_IEN]  = r_reg.ien;
        rd_mux[CCR_DEN]  = r_reg.den;
        rd_mux[CCR_WA]   = r_reg.walloc;
        rd_mux[CCR_BUSY] = r_reg.fst == CAC_F_BUSY;
      end
      CAC_OFS_CACHE_ADDRESS_REG:  rd_mux = r_reg.cache_address_reg;
      CAC_OFS_ACR0:  rd_mux = r_reg.acr0;
      CAC_OFS_ACR1:  rd_mux = r_reg.acr1;
      CAC_OFS_AUSR:  rd_mux = {28'h0, r_reg.ausr};
      CAC_OFS_SRCFC: rd_mux = {29'h0, r_reg.source_space_code_reg};
      CAC_OFS_DSTFC: rd_mux = {29'h0, r_reg.dfc};
      CAC_OFS_PROBE: rd_mux = '0;
      default:       reg_known = 1'b0;
    endcase
  end

  always_comb
  begin
    r_next            = r_reg;
    r_next.pready     = apb_acc;
    r_next.fill_en    = 1'b0;
    r_next.wt_valid   = 1'b0;
    r_next.inv_all_i  = 1'b0;
    r_next.inv_all_d  = 1'b0;
    r_next.inv_line_i = 1'b0;
    r_next.inv_line_d = 1'b0;

    // register answer is staged one cycle into the access phase
    if (apb_acc)
    begin
      // user-state accesses are refused with an error, no effect
      r_next.pslverr = !reg_known || !pprot[0];
      r_next.prdata  = (reg_known && pprot[0] && !pwrite) ? rd_mux : '0;
    end
    if (apb_done && pwrite && !r_reg.pslverr)
    begin
      case (paddr)
        CAC_OFS_CCR:
        begin
          r_next.ien        = pwdata[CCR_IEN];
          r_next.den        = pwdata[CCR_DEN];
          r_next.walloc     = pwdata[CCR_WA];
          r_next.inv_all_i  = pwdata[CCR_ICLR];
          r_next.inv_all_d  = pwdata[CCR_DCLR];
          r_next.inv_line_i = pwdata[CCR_ICLRE];
          r_next.inv_line_d = pwdata[CCR_DCLRE];
        end
        CAC_OFS_CACHE_ADDRESS_REG:  r_next.cache_address_reg = pwdata;
        CAC_OFS_ACR0:  r_next.acr0 = pwdata & ACR_WMASK;
        CAC_OFS_ACR1:  r_next.acr1 = pwdata & ACR_WMASK;
        CAC_OFS_SRCFC: r_next.source_space_code_reg  = pwdata[2:0];
        CAC_OFS_DSTFC: r_next.dfc  = pwdata[2:0];
        CAC_OFS_PROBE:
        begin
          // probe address top byte, direction and space code
          r_next.ausr[1] = acu_hit(r_reg.acr0, pwdata,
                                   pwdata[PRB_RD], pwdata[2:0]);
          r_next.ausr[2] = acu_hit(r_reg.acr1, pwdata,
                                   pwdata[PRB_RD], pwdata[2:0]);
          r_next.ausr[0] = r_next.ausr[1] || r_next.ausr[2];
          r_next.ausr[3] = acu_cacheable(r_reg.acr0, r_reg.acr1, pwdata,
                                         pwdata[PRB_RD], pwdata[2:0]);
        end
        default: r_next.ausr = r_reg.ausr;
      endcase
    end

    // remember each request so a miss can start its line fill
    if (i_req)
    begin
      r_next.i_addr_q = i_addr;
      r_next.i_fc_q   = i_fc;
    end
    if (d_req)
    begin
      r_next.d_addr_q = d_addr;
      r_next.d_fc_q   = d_fc_eff;
      r_next.d_wr_q   = d_write;
    end

    // every store goes out; a hit also updates the cached word
    if (d_req && d_write)
    begin
      r_next.wt_valid = 1'b1;
      r_next.wt_addr  = d_addr;
      r_next.wt_data  = d_wdata;
      r_next.sc       = d_fc_eff;
    end

    case (r_reg.fst)
      CAC_F_IDLE:
      begin
        // one fill at a time; a miss while busy is not queued
        if (ic.miss)
        begin
          r_next.fst       = CAC_F_BUSY;
          r_next.fill_is_d = 1'b0;
          r_next.faddr     = {r_reg.i_addr_q[31:4], 4'h0};
          r_next.ffc       = r_reg.i_fc_q;
        end
        else if (dc.miss && (!r_reg.d_wr_q || r_reg.walloc))
        begin
          r_next.fst       = CAC_F_BUSY;
          r_next.fill_is_d = 1'b1;
          r_next.faddr     = {r_reg.d_addr_q[31:4], 4'h0};
          r_next.ffc       = r_reg.d_fc_q;
        end
        if (r_next.fst == CAC_F_BUSY)
        begin
          r_next.fill_req = 1'b1;
          r_next.beat     = 2'h0;
          if (!(d_req && d_write))
            r_next.sc = r_next.ffc;
        end
      end
      CAC_F_BUSY:
      begin
        if (fill_err)
        begin
          // the partial line is dropped, the old entry is untouched
          r_next.fst      = CAC_F_IDLE;
          r_next.fill_req = 1'b0;
        end
        else if (fill_valid)
        begin
          r_next.fbuf[r_reg.beat] = fill_data;
          r_next.beat             = 2'(r_reg.beat + 2'h1);
          if (r_reg.beat == 2'(CAC_LINE_WORDS - 1))
          begin
            r_next.fst      = CAC_F_IDLE;
            r_next.fill_req = 1'b0;
            r_next.fill_en  = 1'b1;
          end
        end
      end
      default:
      begin
        r_next.fst      = CAC_F_IDLE;
        r_next.fill_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg      <= '0;
      r_reg.fst  <= CAC_F_IDLE;
      r_reg.acr0 <= CAC_RST_WORD;
      r_reg.acr1 <= CAC_RST_WORD;
      r_reg.source_space_code_reg  <= CAC_RST_FC;
      r_reg.dfc  <= CAC_RST_FC;
    end
    else
      r_reg <= r_next;
  end

  // instruction cache on its own buses
  assign ic.lk_req    = i_req;
  assign ic.lk_use    = r_reg.ien &&
                        acu_cacheable(r_reg.acr0, r_reg.acr1, i_addr,
                                      1'b1, i_fc);
  assign ic.lk_write  = 1'b0;
  assign ic.lk_addr   = i_addr;
  assign ic.lk_wdata  = '0;
  assign ic.fill_en   = r_reg.fill_en && !r_reg.fill_is_d;
  assign ic.fill_addr = r_reg.faddr;
  assign ic.fill_line = r_reg.fbuf;
  assign ic.inv_all   = r_reg.inv_all_i;
  assign ic.inv_line  = r_reg.inv_line_i;
  assign ic.inv_addr  = r_reg.cache_address_reg;

  // data cache on its own buses
  assign dc.lk_req    = d_req;
  assign dc.lk_use    = r_reg.den &&
                        acu_cacheable(r_reg.acr0, r_reg.acr1, d_addr,
                                      !d_write, d_fc_eff);
  assign dc.lk_write  = d_write;
  assign dc.lk_addr   = d_addr;
  assign dc.lk_wdata  = d_wdata;
  assign dc.fill_en   = r_reg.fill_en && r_reg.fill_is_d;
  assign dc.fill_addr = r_reg.faddr;
  assign dc.fill_line = r_reg.fbuf;
  assign dc.inv_all   = r_reg.inv_all_d;
  assign dc.inv_line  = r_reg.inv_line_d;
  assign dc.inv_addr  = r_reg.cache_address_reg;

  cac_cache u_icache (
    .pclk    (pclk),
    .presetn (presetn),
    .c       (ic)
  );

  cac_cache u_dcache (
    .pclk    (pclk),
    .presetn (presetn),
    .c       (dc)
  );

  assign prdata          = r_reg.prdata;
  assign pready          = r_reg.pready;
  assign pslverr         = r_reg.pslverr;
  assign i_ack           = ic.ack;
  assign i_hit           = ic.hit;
  assign i_rdata         = ic.rdata;
  assign d_ack           = dc.ack;
  assign d_hit           = dc.hit;
  assign d_rdata         = dc.rdata;
  assign fill_req        = r_reg.fill_req;
  assign fill_addr       = r_reg.faddr;
  assign wt_valid        = r_reg.wt_valid;
  assign wt_addr         = r_reg.wt_addr;
  assign wt_data         = r_reg.wt_data;
  assign space_code_bit0 = r_reg.sc[0];
  assign space_code_bit1 = r_reg.sc[1];
  assign space_code_bit2 = r_reg.sc[2];

endmodule : cac_top

// ### tb/cac_top_monitor.sv
`timescale 1ns/1ps
module cac_top_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [2:0]  pprot,
  input wire logic        pready,
  input wire logic        pslverr,
  // lookups
  input wire logic        i_req,
  input wire logic        i_ack,
  input wire logic        d_req,
  input wire logic        d_write,
  input wire logic [31:0] d_addr,
  input wire logic [31:0] d_wdata,
  input wire logic        d_ack,
  // bus controller
  input wire logic        fill_req,
  input wire logic [31:0] fill_addr,
  input wire logic        fill_valid,
  input wire logic        fill_err,
  input wire logic        wt_valid,
  input wire logic [31:0] wt_addr,
  input wire logic [31:0] wt_data
);
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] beats;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      beats <= 3'h0;
    else if (!fill_req)
      beats <= 3'h0;
    else if (fill_valid)
      beats <= beats + 3'h1;
  apb_wait_a: assert property (
    psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  user_refused_a: assert property (
    psel && penable && !pready && !pprot[0] |=> pslverr)
    else $error("user access not refused");
  look_ack_a: assert property (
    i_ack == $past(i_req) && d_ack == $past(d_req))
    else $error("lookup answer not one cycle after request");
  store_through_a: assert property (
    d_req && d_write |=> wt_valid && wt_addr == $past(d_addr)
      && wt_data == $past(d_wdata))
    else $error("store not written through");
  store_only_a: assert property (!(d_req && d_write) |=> !wt_valid)
    else $error("write-through without store");
  fill_align_a: assert property (fill_req |-> fill_addr[3:0] == 4'h0)
    else $error("fill address not line aligned");
  fill_hold_a: assert property (
    fill_req && !fill_valid && !fill_err |=> fill_req && $stable(fill_addr))
    else $error("fill request dropped between beats");
  four_beats_a: assert property (
    fill_req && fill_valid && !fill_err
      |=> fill_req == ($past(beats) != 3'h3))
    else $error("fill request not ended by fourth beat");
  fill_abort_a: assert property (fill_req && fill_err |=> !fill_req)
    else $error("fill not aborted on bus error");
endmodule : cac_top_monitor
bind cac_top cac_top_monitor u_mon (
  .pclk, .presetn, .psel, .penable, .pprot, .pready, .pslverr,
  .i_req, .i_ack, .d_req, .d_write, .d_addr, .d_wdata, .d_ack,
  .fill_req, .fill_addr, .fill_valid, .fill_err,
  .wt_valid, .wt_addr, .wt_data
);

// ### tb/cac_bus_model.sv
`timescale 1ns/1ps
// memory behind the bus controller; data is a fixed function of address
module cac_bus_model (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // fill request
  input wire logic        fill_req,
  input wire logic [31:0] fill_addr,
  // idle cycles per beat, beat that carries a bus error
  input wire logic [3:0]  gap,
  input wire logic [2:0]  err_beat,
  // beats
  output logic            fill_valid,
  output logic            fill_err,
  output logic [31:0]     fill_data
);
  logic [3:0] wait_cnt;
  logic [2:0] beat;
  always @(posedge pclk or negedge presetn)
  begin
    fill_valid <= 1'h0;
    fill_err   <= 1'h0;
    // released data lines do not keep their last value
    fill_data  <= presetn ? ~fill_data : 32'h0;
    if (!presetn || !fill_req)
    begin
      beat     <= 3'h0;
      wait_cnt <= 4'h0;
    end
    else if (beat < 3'h4 && wait_cnt != gap)
      wait_cnt <= wait_cnt + 4'h1;
    else if (beat < 3'h4)
    begin
      wait_cnt   <= 4'h0;
      beat       <= beat == err_beat ? 3'h4 : beat + 3'h1;
      fill_err   <= beat == err_beat;
      fill_valid <= beat != err_beat;
      fill_data  <= {fill_addr[31:4], beat[1:0], 2'h0} ^ 32'ha5a5_5a5a;
    end
  end
endmodule : cac_bus_model

// ### tb/tb_cac_top.sv
`timescale 1ns/1ps
module tb_cac_top
  import cac_pkg::*;
;
  logic        pclk = 1'h0, presetn = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [2:0]  pprot = 3'h1, i_fc = 3'h6, d_fc = 3'h5;
  logic [31:0] pwdata = 32'h0, i_addr = 32'h0, d_addr = 32'h0;
  logic [31:0] d_wdata = 32'h0, prdata, i_rdata, d_rdata;
  logic [31:0] fill_addr, fill_data, wt_addr, wt_data;
  logic        i_req = 1'h0, d_req = 1'h0, d_write = 1'h0, d_alt = 1'h0;
  logic        pready, pslverr, i_ack, i_hit, d_ack, d_hit, wt_valid;
  logic        fill_req, fill_valid, fill_err;
  logic        space_code_bit0, space_code_bit1, space_code_bit2;
  logic [3:0]  gap = 4'h0;
  logic [2:0]  err_beat = 3'h7;
  int          err_count = 0, n_checks = 0;
  cac_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pprot,
    .pwdata, .prdata, .pready, .pslverr, .i_req, .i_addr, .i_fc, .i_ack,
    .i_hit, .i_rdata, .d_req, .d_write, .d_alt, .d_addr, .d_fc, .d_wdata,
    .d_ack, .d_hit, .d_rdata, .fill_req, .fill_addr, .fill_valid,
    .fill_err, .fill_data, .wt_valid, .wt_addr, .wt_data,
    .space_code_bit0, .space_code_bit1, .space_code_bit2);
  cac_bus_model mem_side (.pclk, .presetn, .fill_req, .fill_addr, .gap,
    .err_beat, .fill_valid, .fill_err, .fill_data);
  always #2 pclk = ~pclk;
  function automatic logic [31:0] mem(input logic [31:0] a);
    return a ^ 32'ha5a5_5a5a;
  endfunction : mem
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, input logic prv, input logic [31:0] exp,
    input logic serr);
    int n;
    n = 0;
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    pprot  <= {2'h0, prv};
    @(posedge pclk);
    penable <= 1'h1;
    // pready, prdata and pslverr are read as sampled at this very edge
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    chk(pready, 1'h1);
    chk(prdata, exp);
    chk(pslverr, serr);
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 1'h1, 32'h0, 1'h0);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0, 1'h1, e, 1'h0);
  endtask : reg_rd
  task automatic look(input logic ds, input logic wr, input logic [31:0] a,
    input logic [31:0] wd, input logic hit, input logic [2:0] sc);
    d_req   <= ds;
    i_req   <= !ds;
    d_write <= wr;
    d_addr  <= a;
    i_addr  <= a;
    d_wdata <= wd;
    @(posedge pclk);
    d_req <= 1'h0;
    i_req <= 1'h0;
    @(negedge pclk);
    chk(ds ? {d_ack, d_hit} : {i_ack, i_hit}, {1'h1, hit});
    if (hit && !wr)
      chk(ds ? d_rdata : i_rdata, mem(a));
    if (wr)
      chk({space_code_bit2, space_code_bit1, space_code_bit0}, sc);
    @(posedge pclk);
  endtask : look
  // waits out one burst; the line is usable one cycle after fill_req has dropped
  task automatic fill_done(input logic [31:0] a, input logic [2:0] sc);
    int n;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (fill_req !== 1'h1 && n < 20);
    chk(fill_addr, {a[31:4], 4'h0});
    chk({space_code_bit2, space_code_bit1, space_code_bit0}, sc);
    while (fill_req === 1'h1 && n < 200)
    begin
      @(negedge pclk);
      n++;
    end
    chk(fill_req, 1'h0);
    @(posedge pclk);
  endtask : fill_done
  task automatic quiet;
    repeat (6) @(negedge pclk);
    chk(fill_req, 1'h0);
    @(posedge pclk);
  endtask : quiet
  task automatic t_regs;
    reg_rd(CAC_OFS_CCR, CAC_RST_WORD);
    reg_wr(CAC_OFS_ACR0, 32'hffff_ffff);
    reg_rd(CAC_OFS_ACR0, ACR_WMASK);
    apb(1'h1, CAC_OFS_ACR0, 32'h0, 1'h0, 32'h0, 1'h1);
    apb(1'h0, CAC_OFS_ACR1, 32'h0, 1'h0, 32'h0, 1'h1);
    reg_rd(CAC_OFS_ACR0, ACR_WMASK);
    reg_wr(CAC_OFS_CACHE_ADDRESS_REG, 32'h1234_5678);
    reg_rd(CAC_OFS_CACHE_ADDRESS_REG, 32'h1234_5678);
    reg_wr(CAC_OFS_SRCFC, 32'hffff_ffff);
    reg_rd(CAC_OFS_SRCFC, 32'h7);
    reg_wr(CAC_OFS_DSTFC, 32'h3);
    reg_rd(CAC_OFS_PROBE, 32'h0);
    apb(1'h0, 8'h20, 32'h0, 1'h1, 32'h0, 1'h1);
  endtask : t_regs
  task automatic t_probe;
    logic [31:0] pv [5] = '{32'h4000_000d, 32'h4000_0005, 32'h4000_0009,
                            32'h4100_000d, 32'h4200_000d};
    logic [31:0] ps [5] = '{32'h7, 32'hd, 32'hd, 32'hd, 32'h8};
    reg_wr(CAC_OFS_ACR0, 32'h4000_8650);
    reg_wr(CAC_OFS_ACR1, 32'h4001_8107);
    for (int k = 0; k < 5; k++)
    begin
      reg_wr(CAC_OFS_PROBE, pv[k]);
      reg_rd(CAC_OFS_AUSR, ps[k]);
    end
    reg_wr(CAC_OFS_CCR, 32'h1);
    i_fc <= 3'h5;
    look(1'h0, 1'h0, 32'h4000_0100, 32'h0, 1'h0, 3'h0);
    quiet;
    i_fc <= 3'h6;
    reg_wr(CAC_OFS_ACR0, 32'h0);
    reg_wr(CAC_OFS_ACR1, 32'h0);
  endtask : t_probe
  task automatic t_ifill;
    gap <= 4'h3;
    look(1'h0, 1'h0, 32'h1230, 32'h0, 1'h0, 3'h0);
    look(1'h0, 1'h0, 32'h2230, 32'h0, 1'h0, 3'h0);
    fill_done(32'h1230, 3'h6);
    gap <= 4'h0;
    for (int k = 0; k < 4; k++)
      look(1'h0, 1'h0, 32'h1230 + 4 * k, 32'h0, 1'h1, 3'h0);
    look(1'h0, 1'h0, 32'h2238, 32'h0, 1'h0, 3'h0);
    fill_done(32'h2238, 3'h6);
    look(1'h0, 1'h0, 32'h2238, 32'h0, 1'h1, 3'h0);
    reg_wr(CAC_OFS_CCR, 32'h9);
    reg_rd(CAC_OFS_CCR, 32'h1);
    look(1'h0, 1'h0, 32'h2238, 32'h0, 1'h0, 3'h0);
    fill_done(32'h2238, 3'h6);
  endtask : t_ifill
  task automatic t_err;
    err_beat <= 3'h2;
    look(1'h0, 1'h0, 32'h3000, 32'h0, 1'h0, 3'h0);
    fill_done(32'h3000, 3'h6);
    err_beat <= 3'h7;
    look(1'h0, 1'h0, 32'h3004, 32'h0, 1'h0, 3'h0);
    fill_done(32'h3004, 3'h6);
    look(1'h0, 1'h0, 32'h3004, 32'h0, 1'h1, 3'h0);
  endtask : t_err
  task automatic t_store;
    reg_wr(CAC_OFS_CCR, 32'h100);
    look(1'h1, 1'h1, 32'h5000, 32'hdead_beef, 1'h0, 3'h5);
    quiet;
    look(1'h1, 1'h0, 32'h5000, 32'h0, 1'h0, 3'h0);
    fill_done(32'h5000, 3'h5);
    look(1'h1, 1'h1, 32'h5004, 32'h1111_2222, 1'h1, 3'h5);
    d_addr <= 32'h5004;
    look(1'h1, 1'h0, 32'h5008, 32'h0, 1'h1, 3'h0);
    reg_wr(CAC_OFS_CCR, 32'h2100);
    d_alt <= 1'h1;
    look(1'h1, 1'h1, 32'h6000, 32'h7, 1'h0, 3'h3);
    d_alt <= 1'h0;
    fill_done(32'h6000, 3'h3);
    look(1'h1, 1'h0, 32'h6004, 32'h0, 1'h1, 3'h0);
  endtask : t_store
  task automatic end_sim;
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial
  begin
    #(20000 * 4);
    err_count++;
    end_sim;
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs;
    t_probe;
    t_ifill;
    t_err;
    t_store;
    end_sim;
  end
endmodule : tb_cac_top
